// [mie_pkg.sv]
// Package of constants for the microcode instruction executor.
// Assumes a 20 MHz system clock and a classic Wishbone register bus.
package mie_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int EXEC_NS       = 260;
  localparam int JUMP_NS       = 520;
  localparam int EXEC_CYC      = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int JUMP_CYC      = (JUMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] EXEC_LAST = 4'(EXEC_CYC - 1);
  localparam logic [3:0] JUMP_LAST = 4'(JUMP_CYC - 1);
  // ==========================================================
  // Instruction classes and operations
  localparam logic [2:0] CLS_IDX = 3'h0;
  localparam logic [2:0] CLS_JMP = 3'h1;
  localparam logic [2:0] CLS_ARI = 3'h2;
  localparam logic [2:0] CLS_SHF = 3'h3;
  localparam logic [2:0] LOP_OR  = 3'h0;
  localparam logic [2:0] LOP_XOR = 3'h1;
  localparam logic [2:0] LOP_AND = 3'h2;
  localparam logic [2:0] LOP_LDR = 3'h3;
  localparam logic [2:0] LOP_LDS = 3'h4;
  localparam logic [2:0] LOP_TXR = 3'h5;
  localparam logic [2:0] LOP_TOR = 3'h6;
  localparam logic [2:0] AOP_ADD = 3'h0;
  localparam logic [2:0] AOP_ADL = 3'h1;
  localparam logic [2:0] AOP_SUB = 3'h2;
  localparam logic [2:0] AOP_SBL = 3'h3;
  localparam logic [2:0] AOP_OR  = 3'h4;
  localparam logic [2:0] AOP_XOR = 3'h5;
  localparam logic [2:0] AOP_AND = 3'h6;
  localparam logic [1:0] FILL_ZERO = 2'h0;
  localparam logic [1:0] FILL_ONE  = 2'h1;
  localparam logic [1:0] FILL_SIGN = 2'h2;
  // ==========================================================
  // Register field codes and condition bits
  localparam logic [3:0] R_A   = 4'h0;
  localparam logic [3:0] R_C   = 4'h1;
  localparam logic [3:0] R_X   = 4'h2;
  localparam logic [3:0] R_Y   = 4'h3;
  localparam logic [3:0] R_PCU = 4'h4;
  localparam logic [3:0] R_PCL = 4'h5;
  localparam logic [3:0] R_EXT = 4'h6;
  localparam int CB_LINK = 0;
  localparam int CB_SIGN = 1;
  localparam int CB_POS  = 2;
  localparam int CB_ZERO = 3;
  localparam int CB_OVF  = 4;
  // ==========================================================
  // Bus map and reset values
  localparam logic [7:0]  ADR_CTRL   = 8'h00;
  localparam logic [7:0]  ADR_STATUS = 8'h04;
  localparam logic [7:0]  ADR_REGS   = 8'h08;
  localparam logic [11:0] PC_RST     = 12'h000;
  localparam logic [7:0]  REG_RST    = 8'h00;
  typedef enum logic [0:0] {ST_HALT = 1'b0, ST_RUN = 1'b1} mie_state_t;
endpackage : mie_pkg

// [mie_core.sv]
// Execution core of a byte-wide microprogrammed controller.
// Assumes a synchronous program memory (data one clock after address)
// and external registers answering reads combinationally on ext_rdata.
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Index steps selected register by one
// - Index carry or borrow goes through link
// - Literal OR, XOR or AND with register
// - Literal loads into register or scratch
// - Test forms update condition register only
// - Conditional jump loads PC when bit matches
// - Bit select field picks condition bit
// - Literal into PC register jumps unconditionally
// - Arithmetic destination zero writes the PC
// - Arithmetic combines scratch and register operands
// - Arithmetic result goes to destination register
// - Shift moves register by one bit
// - Vacated bit gets zero, one or sign
// - Sign fill uses last lost bit
// - Sixteen byte-wide scratch registers
// - Ordinary instruction takes six clocks, 300 ns
// - PC destination takes eleven clocks, 550 ns
// - Condition bit zero is adder carry link
// - Codes 0100 and 0101 are PC parts
// - Accumulator gives low PC byte on arithmetic PC jump
module mie_core
  import mie_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [11:0] pm_addr,
  input  wire logic [15:0] pm_data,
  output logic      [3:0]  ext_addr,
  output logic      [7:0]  ext_wdata,
  output logic             ext_we,
  input  wire logic [7:0]  ext_rdata,
  input  wire logic [1:0]  ext_cond
);
  import mie_pkg::*;

  function automatic logic [3:0] r_field(input logic [15:0] ins);
    r_field = ins[15] ? ins[11:8] : ins[3:0];
  endfunction : r_field

  // ==========================================================
  // Reset and pin synchronisers
  logic [1:0] rst_sync_r;
  logic       rst_n_r;
  logic [1:0] cond_s1_r;
  logic [1:0] cond_s2_r;
  assign rst_n_r = rst_sync_r[1];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cond_s1_r <= 2'h0;
      cond_s2_r <= 2'h0;
    end else begin
      cond_s1_r <= ext_cond;
      cond_s2_r <= cond_s1_r;
    end
  end

  // ==========================================================
  // State
  mie_state_t  st_r;
  logic [3:0]  cnt_r;
  logic [15:0] instr_r;
  logic [11:0] pc_r;
  logic [7:0]  a_r, c_r, x_r, y_r;
  logic [7:0]  scratch_r [16];
  logic        lost_r;
  logic        run_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [3:0]  ext_addr_r;
  logic [7:0]  ext_wdata_r;
  logic        ext_we_r;

  // ==========================================================
  // Decode
  wire        is_lit  = instr_r[15];
  wire [2:0]  cls     = instr_r[14:12];
  wire        is_idx  = !is_lit && cls == CLS_IDX;
  wire        is_jmp  = !is_lit && cls == CLS_JMP;
  wire        is_ari  = !is_lit && cls == CLS_ARI;
  wire        is_shf  = !is_lit && cls == CLS_SHF;
  wire [2:0]  lop     = instr_r[14:12];
  wire [2:0]  aop     = instr_r[11:9];
  wire [7:0]  litv    = instr_r[7:0];
  wire        use_s   = instr_r[8];
  wire        is_test = is_lit && (lop == LOP_TXR || lop == LOP_TOR);
  wire [3:0]  rsel    = r_field(instr_r);
  wire [3:0]  ssel    = is_ari ? instr_r[7:4] : rsel;
  wire        link    = c_r[CB_LINK];
  // Bit select and polarity of a conditional jump
  wire        taken   = is_jmp && (c_r[instr_r[11:9]] == instr_r[8]);

  // Operand fetch; PC parts read as zero since they are write-only
  wire [7:0]  rv = (rsel == R_A) ? a_r : (rsel == R_C) ? c_r :
                   (rsel == R_X) ? x_r : (rsel == R_Y) ? y_r :
                   (rsel >= R_EXT) ? ext_rdata : 8'h00;
  wire [7:0]  sv = scratch_r[ssel];
  wire [7:0]  opnd = use_s ? sv : rv;

  // ==========================================================
  // Shared adder for indexing and arithmetic
  wire        dec   = instr_r[11];
  wire        bylk  = instr_r[10];
  wire        asub  = aop == AOP_SUB || aop == AOP_SBL;
  wire        alnk  = aop == AOP_ADL || aop == AOP_SBL;
  wire [7:0]  add_a = is_ari ? rv : opnd;
  wire [7:0]  add_b = is_ari ? (asub ? ~sv : sv) : (dec ? 8'hff : 8'h00);
  wire        cin   = is_ari ? (alnk ? link : asub) :
                      (bylk ? (dec ? ~link : link) : ~dec);
  wire [8:0]  sum9  = {1'b0, add_a} + {1'b0, add_b} + {8'h00, cin};
  wire        ovf   = (add_a[7] == add_b[7]) && (sum9[7] != add_a[7]);

  wire [7:0]  ari_res = (aop == AOP_OR)  ? (rv | sv) :
                        (aop == AOP_XOR) ? (rv ^ sv) :
                        (aop == AOP_AND) ? (rv & sv) :
                        aop[2] ? rv : sum9[7:0];
  wire [7:0]  lit_res = (lop == LOP_OR || lop == LOP_TOR) ? (litv | rv) :
                        (lop == LOP_XOR || lop == LOP_TXR) ? (litv ^ rv) :
                        (lop == LOP_AND) ? (litv & rv) : litv;

  // Shift by one with selectable fill; the lost bit is kept for chaining
  wire        shr     = instr_r[11];
  wire [1:0]  fill_m  = instr_r[10:9];
  wire        fill_b  = (fill_m == FILL_ONE) ? 1'b1 :
                        (fill_m == FILL_SIGN) ? lost_r : 1'b0;
  wire [7:0]  shf_res = shr ? {fill_b, opnd[7:1]} : {opnd[6:0], fill_b};
  wire        shf_out = shr ? opnd[0] : opnd[7];

  wire [7:0]  res = is_idx ? sum9[7:0] : is_ari ? ari_res :
                    is_shf ? shf_res : lit_res;

  // ==========================================================
  // Write-back decode
  wire        d_reg  = instr_r[8];
  wire        wr_s   = ((is_idx || is_shf) && use_s) || (is_lit && lop == LOP_LDS);
  wire        wr_r   = ((is_idx || is_shf) && !use_s) || (is_ari && d_reg) ||
                       (is_lit && lop <= LOP_LDR);
  wire        wr_pcp = wr_r && (rsel == R_PCU || rsel == R_PCL);
  wire        ari_pc = is_ari && !d_reg;
  wire        pc_dst = wr_pcp || ari_pc || taken;
  wire [3:0]  last   = pc_dst ? JUMP_LAST : EXEC_LAST;
  wire        commit = st_r == ST_RUN && cnt_r == last;
  wire        upd_c  = is_idx || is_ari || (is_lit && lop != LOP_LDR && lop != LOP_LDS);
  wire        arith  = is_idx || (is_ari && !aop[2]);

  wire [11:0] pc_nxt = taken ? {pc_r[11:8], litv} :
                       ari_pc ? {res[3:0], a_r} :
                       (wr_pcp && rsel == R_PCU) ? {res[3:0], pc_r[7:0]} :
                       wr_pcp ? {pc_r[11:8], res} : pc_r + 12'h001;

  logic [7:0] flags;
  always_comb begin
    flags = c_r;
    flags[CB_ZERO] = res == 8'h00;
    flags[CB_POS]  = !res[7] && res != 8'h00;
    if (arith) begin
      flags[CB_LINK] = sum9[8];
      flags[CB_OVF]  = ovf;
      flags[CB_SIGN] = add_a[7];
    end
  end
  wire [7:0] c_nxt = (wr_r && rsel == R_C) ? res : upd_c ? flags : c_r;

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r  <= ST_HALT;
      cnt_r <= 4'h0;
    end else begin
      case (st_r)
        ST_HALT: begin
          cnt_r <= 4'h0;
          if (run_r) st_r <= ST_RUN;
        end
        ST_RUN: begin
          cnt_r <= commit ? 4'h0 : cnt_r + 4'h1;
          if (commit && !run_r) st_r <= ST_HALT;
        end
        default: st_r <= ST_HALT;
      endcase
    end
  end

  // Program memory sees the counter directly; data lands one edge later
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      instr_r    <= 16'h0000;
      ext_addr_r <= 4'h0;
    end else if (st_r == ST_RUN && cnt_r == 4'h1) begin
      instr_r    <= pm_data;
      ext_addr_r <= r_field(pm_data);
    end
  end

  wire clr_pc = ack_r && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0] &&
                wb_dat_i[1] && st_r == ST_HALT;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pc_r   <= PC_RST;
      lost_r <= 1'b0;
    end else if (commit) begin
      pc_r <= pc_nxt;
      if (is_shf) lost_r <= shf_out;
    end else if (clr_pc) begin
      pc_r <= PC_RST;
    end
  end

  // Jumps fall through every write enable below; tests skip the A, X and Y enables but still write the flags in c_r[5:0]
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      a_r <= REG_RST;
      x_r <= REG_RST;
      y_r <= REG_RST;
      c_r <= REG_RST;
    end else begin
      // Pins frozen mid-instruction so a jump on them keeps one period length
      if (st_r != ST_RUN || cnt_r == 4'h0) c_r[7:6] <= cond_s2_r;
      if (commit) begin
        c_r[5:0] <= c_nxt[5:0];
        if (wr_r && rsel == R_A) a_r <= res;
        if (wr_r && rsel == R_X) x_r <= res;
        if (wr_r && rsel == R_Y) y_r <= res;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_scr
      always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
          scratch_r[gi] <= REG_RST;
        end else if (commit && wr_s && ssel == 4'(gi)) begin
          scratch_r[gi] <= res;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_we_r    <= 1'b0;
      ext_wdata_r <= 8'h00;
    end else begin
      ext_we_r <= commit && wr_r && rsel >= R_EXT;
      if (commit) ext_wdata_r <= res;
    end
  end

  // ==========================================================
  // Wishbone slave; writes land on the acknowledging edge
  wire        wb_req = wb_cyc_i && wb_stb_i;
  wire        wb_wr  = wb_req && wb_we_i && ack_r;
  wire [31:0] rd_mux = (wb_adr_i == ADR_CTRL)   ? {31'h0, run_r} :
                       (wb_adr_i == ADR_STATUS) ? {18'h0, lost_r, pc_r, st_r == ST_RUN} :
                       (wb_adr_i == ADR_REGS)   ? {y_r, x_r, c_r, a_r} : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      run_r <= 1'b0;
    end else begin
      ack_r <= wb_req && !ack_r;
      if (wb_req && !ack_r) dat_r <= rd_mux;
      if (wb_wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) run_r <= wb_dat_i[0];
    end
  end

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;
  assign pm_addr   = pc_r;
  assign ext_addr  = ext_addr_r;
  assign ext_wdata = ext_wdata_r;
  assign ext_we    = ext_we_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_r);

  exec_period_a: assert property (commit && !pc_dst |-> $past(cnt_r, 5) == 4'h0 && $past(st_r, 5) == ST_RUN)
    else $error("Ordinary instruction not six cycles");
  jump_period_a: assert property (commit && pc_dst |-> $past(cnt_r, 10) == 4'h0)
    else $error("PC destination not eleven cycles");
  cond_jump_a: assert property (commit && taken |=> pc_r == {$past(pc_r[11:8]), $past(instr_r[7:0])})
    else $error("Taken jump went to wrong address");
  no_jump_a: assert property (commit && is_jmp && !taken |=> pc_r == $past(pc_r) + 12'h001)
    else $error("Untaken jump did not fall through");
  test_quiet_a: assert property (commit && (is_jmp || is_test) |=>
      a_r == $past(a_r) && x_r == $past(x_r) && y_r == $past(y_r) && !ext_we)
    else $error("Test or jump changed a register");
  index_step_a: assert property (commit && is_idx && dec && !bylk && !use_s && rsel == R_X
      |=> x_r == $past(x_r) - 8'h01)
    else $error("Index did not step down X");
  sign_fill_a: assert property (commit && is_shf && shr && fill_m == FILL_SIGN && !use_s && rsel == R_X
      |=> x_r[7] == $past(lost_r))
    else $error("Sign fill lost bit wrong");
  link_carry_a: assert property (commit && is_ari && aop == AOP_ADD && rsel != R_C
      |=> c_r[0] == $past(sum9[8]))
    else $error("Link flag not adder carry");
  dzero_jump_a: assert property (commit && ari_pc |=> pc_r[7:0] == $past(a_r))
    else $error("Accumulator not in low PC byte");

  taken_c: cover property (commit && taken);
  dzero_c: cover property (commit && ari_pc);
  signfill_c: cover property (commit && is_shf && fill_m == FILL_SIGN);
endmodule : mie_core

// [mie_far_model.sv]
// Far side of the executor: program memory and external registers.
// Assumes pm_addr is registered; the word follows one clock later.
`timescale 1ns/1ps
module mie_far_model (
  input  wire logic        clk_sys,
  input  wire logic [11:0] pm_addr,
  output logic      [15:0] pm_data,
  input  wire logic [3:0]  ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_we,
  output logic      [7:0]  ext_rdata
);
  import mie_pkg::*;
  logic [15:0] mem [0:4095];
  logic [7:0]  ext_mem [0:15];
  logic [7:0]  junk_r;
  // ==========
  // Unused words jump to themselves, so a stray jump parks the core
  initial begin
    junk_r = 8'h5a;
    for (int i = 0; i < 4096; i++)
      mem[i] = {1'b1, LOP_LDR, R_PCL, 8'(i)};
    for (int i = 0; i < 16; i++)
      ext_mem[i] = 8'h00;
  end
  always @(posedge clk_sys) begin
    pm_data <= mem[pm_addr];
    junk_r  <= ~junk_r;
    if (ext_we)
      ext_mem[ext_addr] <= ext_wdata;
  end
  // No assembly answers internal codes, so the return bus toggles
  assign ext_rdata = (ext_addr >= 4'h6) ? ext_mem[ext_addr] : junk_r;
endmodule : mie_far_model

// [testbench.sv]
// Self-checking bench: two fixed programs with random operands through the executor.
// Assumes the far model above and the Wishbone map of the package.
`timescale 1ns/1ps
module testbench;
  import mie_pkg::*;
  logic        clk_sys, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, ext_we;
  logic [7:0]  wb_adr, ext_wdata, ext_rdata;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [11:0] pm_addr, last_pc;
  logic [15:0] pm_data;
  logic [3:0]  ext_addr, wb_sel;
  logic [1:0]  ext_cond;
  int          err_count, checked, seed, cyc_cnt;
  int          per [int];
  mie_core uut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .pm_addr(pm_addr), .pm_data(pm_data), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_rdata(ext_rdata), .ext_cond(ext_cond));
  mie_far_model far (.clk_sys(clk_sys), .pm_addr(pm_addr), .pm_data(pm_data),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_rdata(ext_rdata));
  // ==========
  // Clock, watchdog and period monitor
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (50000) @(posedge clk_sys);
    err_count++;
    report_and_stop;
  end
  always @(posedge clk_sys) begin
    if (reset_n && pm_addr !== last_pc) begin
      per[last_pc] = cyc_cnt;
      cyc_cnt = 1;
      last_pc = pm_addr;
    end else
      cyc_cnt++;
  end
  // ==========
  // Encoders and expectations
  function automatic logic [15:0] lit(input logic [2:0] op, input logic [3:0] r, input logic [7:0] l);
    return {1'b1, op, r, l};
  endfunction : lit
  function automatic logic [15:0] cj(input logic p, input logic [7:0] t);
    return {1'b0, CLS_JMP, 3'(CB_ZERO), p, t};
  endfunction : cj
  function automatic logic [15:0] ari(input logic [2:0] op, input logic d, input logic [3:0] s, r);
    return {1'b0, CLS_ARI, op, d, s, r};
  endfunction : ari
  function automatic logic [15:0] ixs(input logic [2:0] c, input logic f, g, input logic [1:0] h,
                                      input logic sc, input logic [3:0] r);
    return {1'b0, c, f, h, sc, 4'h0, r} | {5'h0, g, 10'h0};
  endfunction : ixs
  function automatic logic [23:0] exp_a(input logic [7:0] a, l1, x, l2, y, l3);
    logic [7:0] y1;
    y1 = y & l3;
    return {y1, (y1 == 8'h00) ? (x ^ l2) : 8'h00, ~(a | l1)};
  endfunction : exp_a
  function automatic logic [36:0] exp_b(input logic [7:0] a, s, y, x);
    logic [8:0] sm;
    logic [7:0] a3, x3, y2;
    sm = a + s;
    a3 = {sm[6:0], 1'b0};
    x3 = {sm[7], 7'((x - 8'h01) >> 1)};
    y2 = y + {7'h0, sm[8]};
    return {x3[3:0], a3, y2[7], y2[6:0], 1'b1, x3, a3};
  endfunction : exp_b
  // ==========
  // Bus cycles, compare and verdict
  task automatic chk(input string name, input logic [36:0] exp, input logic [36:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_sys);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_sel   <= 4'hf;
    wb_adr   <= adr;
    wb_dat_w <= dat;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic run_prog(input logic [11:0] pc, output logic [31:0] regs, st);
    wb(1'b1, ADR_CTRL, 32'h2, st);
    wb(1'b1, ADR_CTRL, 32'h1, st);
    do begin
      wb(1'b0, ADR_STATUS, 32'h0, st);
    end while (st[12:1] !== pc);
    wb(1'b1, ADR_CTRL, 32'h0, st);
    do begin
      wb(1'b0, ADR_STATUS, 32'h0, st);
    end while (st[0] !== 1'b0);
    wb(1'b0, ADR_REGS, 32'h0, regs);
  endtask : run_prog
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // Main sequence
  initial begin
    logic [7:0]  a, s, x, y, l1, l2, l3;
    logic [3:0]  k;
    logic [31:0] regs, st;
    logic [36:0] e;
    logic [15:0] pa [0:14];
    logic [15:0] pb [0:13];
    seed = 32'h8036;
    {err_count, checked, cyc_cnt} = '0;
    {reset_n, wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat_w, ext_cond, last_pc} = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wb(1'b0, ADR_STATUS, 32'h0, st);
    chk("status_rst", 37'h0, st);
    wb(1'b0, ADR_REGS, 32'h0, regs);
    chk("regs_rst", 37'h0, regs);
    wb(1'b1, 8'h10, 32'hffffffff, st);
    wb(1'b0, 8'h10, 32'h0, st);
    chk("unmapped", 37'h0, st);
    for (int it = 0; it < 6; it++) begin
      {a, s, y, l1, l2, l3} = 48'({$random(seed), $random(seed)});
      if (it == 0)
        {a, s, y, l3} = 32'hff01ff00;
      x = (8'($random(seed)) | 8'h10) + 8'h01;
      k = 4'($random(seed));
      ext_cond <= 2'($random(seed));
      pa = '{lit(LOP_LDR, R_A, a), lit(LOP_OR, R_A, l1), lit(LOP_LDR, R_X, x), lit(LOP_XOR, R_X, l2),
             lit(LOP_LDR, R_Y, y), lit(LOP_AND, R_Y, l3), lit(LOP_TXR, R_Y, y & l3), cj(1'b1, 8'd9),
             lit(LOP_LDR, R_Y, ~(y & l3)), cj(1'b0, 8'd11), lit(LOP_XOR, R_A, 8'hff),
             lit(LOP_TOR, R_Y, 8'h00), cj(1'b1, 8'd14), lit(LOP_LDR, R_X, 8'h00), lit(LOP_LDR, R_PCL, 8'd14)};
      for (int i = 0; i < 15; i++)
        far.mem[i] = pa[i];
      run_prog(12'd14, regs, st);
      chk("regs_a", exp_a(a, l1, x, l2, y, l3), {regs[31:16], regs[7:0]});
      chk("pc_a", 37'd14, st[12:1]);
      chk("time_plain", EXEC_CYC, per[1]);
      chk("time_taken", JUMP_CYC, per[7]);
      chk("time_skip", EXEC_CYC, per[9]);
      pb = '{lit(LOP_LDS, k, s), lit(LOP_LDR, R_Y, y), lit(LOP_LDR, R_A, a), ari(AOP_ADD, 1'b1, k, R_A),
             ixs(CLS_IDX, 1'b0, 1'b1, 2'h0, 1'b0, R_Y), lit(LOP_LDR, R_X, x),
             ixs(CLS_IDX, 1'b1, 1'b0, 2'h0, 1'b0, R_X), ixs(CLS_IDX, 1'b0, 1'b0, 2'h0, 1'b1, k),
             ixs(CLS_SHF, 1'b0, 1'b0, FILL_ZERO, 1'b0, R_A), ixs(CLS_SHF, 1'b1, 1'b0, FILL_SIGN, 1'b0, R_X),
             ixs(CLS_SHF, 1'b0, 1'b0, FILL_ONE, 1'b0, R_Y), lit(LOP_LDR, R_EXT, 8'h00),
             ari(AOP_OR, 1'b1, k, R_EXT), ari(3'h7, 1'b0, 4'h0, R_X)};
      for (int i = 0; i < 14; i++)
        far.mem[i] = pb[i];
      e = exp_b(a, s, y, x);
      run_prog(e[36:25], regs, st);
      chk("regs_b", e[23:0], {regs[31:16], regs[7:0]});
      chk("pc_b", e[36:25], st[12:1]);
      chk("lost_bit", e[24], st[13]);
      chk("scratch", 8'(s + 8'h01), far.ext_mem[6]);
      chk("time_jump", JUMP_CYC, per[13]);
    end
    report_and_stop;
  end
endmodule : testbench
